// ===== core/timer_capture_compare_unit.sv
// Capture and compare section of a 16-bit free-running timer
//
// Design decision made here: the Wishbone slave port.
module timer_capture_compare_unit (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic por_in,
  input wire logic ce_in,
  input wire logic stop_in,
  input wire logic capture_input_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic timer_irq_out
);
  // ==========================================
  // State
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] presc_reg;
  logic [15:0] cnt_reg;
  logic pin_prev_reg;
  logic [15:0] cap_reg;
  logic cap_block_reg;
  logic pend_reg;
  logic [15:0] pend_val_reg;
  logic [15:0] cmp_reg;
  logic cmp_block_reg;
  logic [7:0] lo_latch_reg;
  logic latched_reg;
  logic irq_reg;
  tcc_pkg::ctrl_s ctrl_reg;
  tcc_pkg::flags_s flags_reg;
  tcc_pkg::flags_s arm_reg;

  // ==========================================
  // Bus decode
  logic req;
  logic rd;
  logic wr;
  logic [5:0] idx;
  logic run;
  logic tick;
  logic edge_hit;
  logic cap_set;
  logic wake_commit;
  logic cmp_hit;
  logic ovf_hit;
  tcc_pkg::flags_s set_v;
  tcc_pkg::flags_s clr_v;
  logic [15:0] cnt_plus;
  logic [7:0] status_v;
  logic [7:0] ctrl_v;

  // One access per request; ack drops the cycle after it is given
  assign req = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign rd = req & ~wb_we_in;
  assign wr = req & wb_we_in & wb_sel_in[0];
  assign idx = wb_adr_in[7:2];
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;
  assign timer_irq_out = irq_reg;

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in) begin
        ack_reg <= 1'b0;
      end else begin
        ack_reg <= req;
      end
    end
  end

  // ==========================================
  // Prescaler and counter
  assign run = ~stop_in;
  // (R4) one count per four clocks
  assign tick = run & (presc_reg == tcc_pkg::PRESC_LAST);
  assign cnt_plus = cnt_reg + 16'h0001;

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in) begin
        presc_reg <= 2'h0;
      end else if (run) begin
        presc_reg <= presc_reg + 2'h1;
      end
    end
  end

  // Stop freezes the count; external reset forces the preset value
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      // (R17) hold in stop, preset on reset
      if (srst_in) begin
        cnt_reg <= tcc_pkg::CNT_RESET;
      end else if (tick) begin
        cnt_reg <= cnt_plus;
      end
    end
  end

  // ==========================================
  // Capture edge detection
  // Pin is taken as synchronous; one sample of history is enough
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      pin_prev_reg <= capture_input_in;
    end
  end

  // (R2) polarity from edge select
  assign edge_hit = ctrl_reg.edge_sel ? (capture_input_in & ~pin_prev_reg)
                                      : (~capture_input_in & pin_prev_reg);
  assign wake_commit = run & pend_reg;
  assign cap_set = (edge_hit & run & ~cap_block_reg) | (wake_commit & ~cap_block_reg);

  // (R18) arm in stop, commit on wake, drop on reset
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        pend_reg <= 1'b0;
        pend_val_reg <= 16'h0000;
      end else if (edge_hit && !run && !pend_reg) begin
        pend_reg <= 1'b1;
        pend_val_reg <= cnt_plus;
      end else if (wake_commit) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Capture registers survive the ordinary reset; power-on clears them
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      // (R7) only power-on touches capture data
      if (por_in) begin
        cap_reg <= 16'h0000;
      end else if (!srst_in && cap_set) begin
        // (R1) (R3) (R19) latest capture, one count ahead
        cap_reg <= wake_commit ? pend_val_reg : cnt_plus;
      end
    end
  end

  // High byte read freezes the pair from the next cycle; a capture in the high read cycle itself is not blocked
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        cap_block_reg <= 1'b0;
      end else if (rd && idx == tcc_pkg::IDX_CAP_HI) begin
        // (R5) block until low read
        cap_block_reg <= 1'b1;
      end else if (rd && idx == tcc_pkg::IDX_CAP_LO) begin
        cap_block_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Compare
  // (R8) (R10) match on prescaler tick unless suspended
  assign cmp_hit = tick & ~cmp_block_reg & (cnt_reg == cmp_reg);
  // (R12) wrap detection
  assign ovf_hit = tick & (cnt_reg == tcc_pkg::CNT_TOP);

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (por_in) begin
        cmp_reg <= 16'h0000;
      end else if (wr && idx == tcc_pkg::IDX_CMP_HI) begin
        cmp_reg[15:8] <= wb_dat_in[7:0];
      end else if (wr && idx == tcc_pkg::IDX_CMP_LO) begin
        cmp_reg[7:0] <= wb_dat_in[7:0];
      end
    end
  end

  // (R10) high write suspends, low write resumes
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        cmp_block_reg <= 1'b0;
      end else if (wr && idx == tcc_pkg::IDX_CMP_HI) begin
        cmp_block_reg <= 1'b1;
      end else if (wr && idx == tcc_pkg::IDX_CMP_LO) begin
        cmp_block_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Flags: set wins over clear
  always_comb begin
    set_v.cap = cap_set;
    set_v.cmp = cmp_hit;
    set_v.ovf = ovf_hit;
    // (R6) status read then capture low read
    clr_v.cap = arm_reg.cap & rd & (idx == tcc_pkg::IDX_CAP_LO);
    // (R11) status read then compare low access
    clr_v.cmp = arm_reg.cmp & req & (idx == tcc_pkg::IDX_CMP_LO);
    // (R12) status read then counter low read
    clr_v.ovf = arm_reg.ovf & rd & (idx == tcc_pkg::IDX_CNT_LO);
  end

  // (R15) flags ignore status writes and the ordinary reset
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (por_in) begin
        flags_reg <= '0;
      end else if (!srst_in) begin
        flags_reg <= set_v | (flags_reg & ~clr_v);
      end
    end
  end

  // A status read arms only the flags seen set at that moment
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        arm_reg <= '0;
      end else if (rd && idx == tcc_pkg::IDX_STATUS) begin
        arm_reg <= arm_reg | flags_reg;
      end else begin
        arm_reg <= arm_reg & ~clr_v;
      end
    end
  end

  // ==========================================
  // Control register
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (por_in) begin
        ctrl_reg <= '0;
      end else if (srst_in) begin
        // (R14) keep edge select across reset
        ctrl_reg <= '{cap_ie: 1'b0, cmp_ie: 1'b0, ovf_ie: 1'b0, edge_sel: ctrl_reg.edge_sel};
      end else if (wr && idx == tcc_pkg::IDX_CTRL) begin
        ctrl_reg.cap_ie <= wb_dat_in[tcc_pkg::BIT_CAP_IE];
        ctrl_reg.cmp_ie <= wb_dat_in[tcc_pkg::BIT_CMP_IE];
        ctrl_reg.ovf_ie <= wb_dat_in[tcc_pkg::BIT_OVF_IE];
        ctrl_reg.edge_sel <= wb_dat_in[tcc_pkg::BIT_EDGE];
      end
    end
  end

  // ==========================================
  // Interrupt request
  // Runs in wait mode too, so it can wake the core
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        irq_reg <= 1'b0;
      end else begin
        // (R9) (R13) (R16) enables gate flags
        irq_reg <= (flags_reg.cap & ctrl_reg.cap_ie) | (flags_reg.cmp & ctrl_reg.cmp_ie)
                 | (flags_reg.ovf & ctrl_reg.ovf_ie);
      end
    end
  end

  // ==========================================
  // Counter low byte latch for coherent reads
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in || por_in) begin
        latched_reg <= 1'b0;
        lo_latch_reg <= 8'h00;
      end else if (rd && idx == tcc_pkg::IDX_CNT_HI && !latched_reg) begin
        latched_reg <= 1'b1;
        lo_latch_reg <= cnt_reg[7:0];
      end else if (rd && idx == tcc_pkg::IDX_CNT_LO) begin
        latched_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Read data
  always_comb begin
    status_v = 8'h00;
    status_v[tcc_pkg::BIT_CAP_F] = flags_reg.cap;
    status_v[tcc_pkg::BIT_CMP_F] = flags_reg.cmp;
    status_v[tcc_pkg::BIT_OVF_F] = flags_reg.ovf;
    ctrl_v = 8'h00;
    ctrl_v[tcc_pkg::BIT_CAP_IE] = ctrl_reg.cap_ie;
    ctrl_v[tcc_pkg::BIT_CMP_IE] = ctrl_reg.cmp_ie;
    ctrl_v[tcc_pkg::BIT_OVF_IE] = ctrl_reg.ovf_ie;
    ctrl_v[tcc_pkg::BIT_EDGE] = ctrl_reg.edge_sel;
  end

  // Unmapped indices read zero; upper 24 bits always zero
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (srst_in) begin
        rdata_reg <= 32'h0000_0000;
      end else if (req) begin
        rdata_reg <= 32'h0000_0000;
        case (idx)
          // (R21) control and status locations
          tcc_pkg::IDX_CTRL: rdata_reg[7:0] <= ctrl_v;
          tcc_pkg::IDX_STATUS: rdata_reg[7:0] <= status_v;
          tcc_pkg::IDX_CAP_HI: rdata_reg[7:0] <= cap_reg[15:8];
          tcc_pkg::IDX_CAP_LO: rdata_reg[7:0] <= cap_reg[7:0];
          tcc_pkg::IDX_CMP_HI: rdata_reg[7:0] <= cmp_reg[15:8];
          tcc_pkg::IDX_CMP_LO: rdata_reg[7:0] <= cmp_reg[7:0];
          tcc_pkg::IDX_CNT_HI: rdata_reg[7:0] <= cnt_reg[15:8];
          tcc_pkg::IDX_CNT_LO: rdata_reg[7:0] <= latched_reg ? lo_latch_reg : cnt_reg[7:0];
          default: rdata_reg[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================
  // Assertions
  cap_value_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R3
    (ce_in && !srst_in && run && edge_hit && !cap_block_reg && !pend_reg) |=> cap_reg == $past(cnt_reg) + 16'h0001)
    else $error("capture value not counter plus one");

  edge_rise_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R2
    (ce_in && !srst_in && run && ctrl_reg.edge_sel && capture_input_in && !pin_prev_reg && !cap_block_reg)
    |=> flags_reg.cap)
    else $error("rising edge did not set capture flag");

  presc_hold_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R4
    (ce_in && !srst_in && presc_reg != tcc_pkg::PRESC_LAST) |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved off the prescaler tick");

  cap_block_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R5
    (ce_in && cap_block_reg) |=> cap_reg == $past(cap_reg))
    else $error("capture changed while blocked");

  cmp_set_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R8
    (ce_in && !srst_in && tick && !cmp_block_reg && cnt_reg == cmp_reg) |=> flags_reg.cmp)
    else $error("match did not set compare flag");

  cmp_suspend_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R10
    (ce_in && cmp_block_reg && !flags_reg.cmp) |=> !flags_reg.cmp)
    else $error("compare flag set while suspended");

  ovf_wrap_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R12
    (ce_in && !srst_in && tick && cnt_reg == tcc_pkg::CNT_TOP) |=> flags_reg.ovf && cnt_reg == 16'h0000)
    else $error("wrap did not set overflow flag");

  irq_gate_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R13
    (ce_in && !srst_in && ((flags_reg.cap && ctrl_reg.cap_ie) || (flags_reg.cmp && ctrl_reg.cmp_ie)))
    |=> timer_irq_out)
    else $error("enabled flag raised no interrupt");

  ovf_irq_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R13
    (ce_in && !srst_in && flags_reg.ovf && ctrl_reg.ovf_ie) |=> timer_irq_out)
    else $error("overflow flag raised no interrupt");

  cap_clear_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R6
    (ce_in && !srst_in && clr_v.cap && !cap_set) |=> !flags_reg.cap)
    else $error("capture flag not cleared");

  status_write_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R15
    (ce_in && !srst_in && wr && idx == tcc_pkg::IDX_STATUS && set_v == '0) |=> flags_reg == $past(flags_reg))
    else $error("status write changed flags");

  reset_keep_a: assert property (@(posedge clk_in) disable iff (por_in) // R7
    (ce_in && srst_in && !por_in) |=> cap_reg == $past(cap_reg))
    else $error("reset changed capture data");

  stop_hold_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in) // R17
    (ce_in && !srst_in && stop_in) |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved in stop mode");

  bus_ack_a: assert property (@(posedge clk_in) disable iff (srst_in || por_in)
    (ce_in && req) |=> wb_ack_out ##1 !wb_ack_out || !ce_in)
    else $error("ack not a single cycle");
endmodule : timer_capture_compare_unit

// ===== pkg/tcc_pkg.sv
// Constants and carrier types for the timer capture and compare unit
// Contract
// (R1) Active pin edge copies counter to capture
// (R2) Edge select: one rising, zero falling
// (R3) Captured value is counter plus one
// (R4) Counter advances every four bus clocks
// (R5) High capture read blocks until low read
// (R6) Capture flag cleared by status then low
// (R7) Reset leaves capture registers unchanged
// (R8) Compare every fourth clock sets compare flag
// (R9) Compare enable passes flag to interrupt
// (R10) Compare high write suspends matching until low
// (R11) Compare flag cleared by status then low
// (R12) Wrap sets overflow; status then counter low
// (R13) Capture and overflow enables gate interrupt
// (R14) Reset clears control except edge select
// (R15) Status writes ignored; reset keeps flags
// (R16) Wait mode: timer runs, interrupts wake
// (R17) Stop holds counter; reset forces FFFC
// (R18) Stop edge arms capture, shown on wake
// (R19) Capture registers hold most recent capture
// (R20) Software masks interrupts around compare update
// (R21) Control at 0x12, status at 0x13
package tcc_pkg;
  // ==========================================
  // Register indices (byte address is four times)
  localparam logic [5:0] IDX_CTRL = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h13;
  localparam logic [5:0] IDX_CAP_HI = 6'h14;
  localparam logic [5:0] IDX_CAP_LO = 6'h15;
  localparam logic [5:0] IDX_CMP_HI = 6'h16;
  localparam logic [5:0] IDX_CMP_LO = 6'h17;
  localparam logic [5:0] IDX_CNT_HI = 6'h18;
  localparam logic [5:0] IDX_CNT_LO = 6'h19;
  // ==========================================
  // Field positions in control and status
  localparam int BIT_CAP_IE = 7;
  localparam int BIT_CMP_IE = 6;
  localparam int BIT_OVF_IE = 5;
  localparam int BIT_EDGE = 1;
  localparam int BIT_CAP_F = 7;
  localparam int BIT_CMP_F = 6;
  localparam int BIT_OVF_F = 5;
  // ==========================================
  // Reset and timing values
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic cap_ie;
    logic cmp_ie;
    logic ovf_ie;
    logic edge_sel;
  } ctrl_s;
  typedef struct packed {
    logic cap;
    logic cmp;
    logic ovf;
  } flags_s;
endpackage : tcc_pkg

// ===== tb/capture_pin_model.sv
// Behavioural source driving the capture pin with a settable reaction delay
module capture_pin_model (
  input wire logic clk_in,
  input wire logic level_in,
  input wire logic [3:0] delay_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg;
  initial begin
    pin_out = 1'h0;
    wait_reg = 4'h0;
  end
  // Follow the requested level once the delay has run out; a slow source tests the edge detector
  always @(posedge clk_in) begin
    if (level_in == pin_out) wait_reg <= 4'h0;
    else if (wait_reg >= delay_in) pin_out <= level_in;
    else wait_reg <= wait_reg + 4'h1;
  end
endmodule : capture_pin_model

// ===== tb/timer_capture_compare_unit_tb_top.sv
// Self-checking testbench of the timer capture and compare unit
module timer_capture_compare_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Stimulus and observation signals
  logic clk_in = 1'h0;
  logic srst_in, por_in, ce_in, stop_in, pin, lvl, wb_cyc, wb_stb, wb_we, wb_ack, irq, es;
  logic [3:0] dly, wb_sel;
  logic [7:0] wb_adr, q;
  logic [31:0] wb_wdat, wb_rdat;
  logic [15:0] c, v, t;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h52AD1700;
  int i;
  // Free-running bench clock, 100 ns period
  always #50 clk_in = ~clk_in;
  // ==========================================
  // Design and pin source
  timer_capture_compare_unit i_dut (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in), .ce_in(ce_in),
    .stop_in(stop_in), .capture_input_in(pin), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .timer_irq_out(irq));
  capture_pin_model i_pin (.clk_in(clk_in), .level_in(lvl), .delay_in(dly), .pin_out(pin));
  // ==========================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Classic single cycle; read data is taken at the edge where ack is seen
  task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= 4'h1;
    wb_wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'h1 && n < 20);
    if (wb_ack !== 1'h1) begin
      n_fail++;
      wrap_up();
    end
    q = wb_rdat[7:0];
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask : bus
  // High byte first so the low byte is held until read
  task automatic rd16(input logic [5:0] idx, output logic [15:0] r);
    bus(1'h0, idx, 8'h00);
    r[15:8] = q;
    bus(1'h0, idx + 6'h01, 8'h00);
    r[7:0] = q;
  endtask : rd16
  task automatic pin_to(input logic level);
    int n;
    lvl <= level;
    dly <= {2'h0, 2'($random(seed))};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pin !== level && n < 20);
    if (pin !== level) begin
      n_fail++;
      wrap_up();
    end
    repeat (3) @(posedge clk_in);
  endtask : pin_to
  task automatic stat(input string name, input logic [7:0] exp);
    bus(1'h0, tcc_pkg::IDX_STATUS, 8'h00);
    chk(name, {8'h00, q & 8'hE0}, {8'h00, exp});
  endtask : stat
  // ==========================================
  // Main sequence
  initial begin
    srst_in = 1'h1; por_in = 1'h1; ce_in = 1'h1; stop_in = 1'h0; lvl = 1'h0; dly = 4'h0;
    wb_cyc = 1'h0; wb_stb = 1'h0; wb_we = 1'h0; wb_adr = 8'h00; wb_sel = 4'h0; wb_wdat = 32'h0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'h0;
    por_in <= 1'h0;
    bus(1'h0, tcc_pkg::IDX_CTRL, 8'h00);
    chk("ctrl after power-on", {8'h00, q}, 16'h0000);
    bus(1'h0, 6'h3F, 8'h00);
    chk("unmapped read", {8'h00, q}, 16'h0000);
    // Hi takes are 44 clocks apart, so exactly 11 ticks
    rd16(tcc_pkg::IDX_CNT_HI, c);
    repeat (38) @(posedge clk_in);
    rd16(tcc_pkg::IDX_CNT_HI, v);
    chk("count rate", v - c, 16'h000B);
    // Counter wrapped through zero, which also matched the cleared compare value
    stat("wrap flags", 8'h60);
    bus(1'h1, tcc_pkg::IDX_STATUS, 8'h00);
    stat("status write", 8'h60);
    t = 16'($random(seed));
    bus(1'h1, tcc_pkg::IDX_CTRL, t[7:0] & 8'hFD);
    bus(1'h0, tcc_pkg::IDX_CTRL, 8'h00);
    chk("ctrl readback", {8'h00, q}, {8'h00, t[7:0] & 8'hE0});
    repeat (2) @(posedge clk_in);
    chk("irq gating", {15'h0, irq}, {15'h0, t[6] | t[5]});
    // Capture edge while stopped, then leave stop through reset
    bus(1'h1, tcc_pkg::IDX_CTRL, 8'hE2);
    stop_in <= 1'h1;
    pin_to(1'h1);
    srst_in <= 1'h1;
    @(posedge clk_in);
    srst_in <= 1'h0;
    stop_in <= 1'h0;
    rd16(tcc_pkg::IDX_CNT_HI, c);
    chk("reset exit count", c, 16'hFFFC);
    bus(1'h0, tcc_pkg::IDX_CTRL, 8'h00);
    chk("ctrl after reset", {8'h00, q}, 16'h0002);
    stat("flags kept", 8'h60);
    repeat (30) @(posedge clk_in);
    stat("arm flags", 8'h60);
    bus(1'h0, tcc_pkg::IDX_CMP_LO, 8'h00);
    bus(1'h0, tcc_pkg::IDX_CNT_LO, 8'h00);
    stat("flags cleared", 8'h00);
    // Both polarities, then random ones; the opposite transition must not capture
    for (i = 0; i < 4; i++) begin
      es = (i < 2) ? i[0] : 1'($random(seed));
      bus(1'h1, tcc_pkg::IDX_CTRL, {1'h1, 5'h00, es, 1'h0});
      pin_to(es);
      bus(1'h0, tcc_pkg::IDX_STATUS, 8'h00);
      bus(1'h0, tcc_pkg::IDX_CAP_LO, 8'h00);
      pin_to(~es);
      stat("opposite edge", 8'h00);
      rd16(tcc_pkg::IDX_CNT_HI, c);
      pin_to(es);
      stat("capture flag", 8'h80);
      chk("capture irq", {15'h0, irq}, 16'h0001);
      rd16(tcc_pkg::IDX_CAP_HI, v);
      chk("capture window", {15'h0, (v - c) >= 16'h0001 && (v - c) <= 16'h0005}, 16'h0001);
      stat("capture cleared", 8'h00);
    end
    // Edge while the high byte read is pending is refused
    bus(1'h0, tcc_pkg::IDX_CAP_HI, 8'h00);
    pin_to(~es);
    pin_to(es);
    bus(1'h0, tcc_pkg::IDX_CAP_LO, 8'h00);
    chk("blocked capture", {8'h00, q}, {8'h00, v[7:0]});
    stat("blocked flag", 8'h00);
    pin_to(~es);
    pin_to(es);
    rd16(tcc_pkg::IDX_CAP_HI, t);
    chk("newest capture", {15'h0, t != v}, 16'h0001);
    // The newest capture left its flag set; clear it before the compare checks
    stat("newest flag", 8'h80);
    bus(1'h0, tcc_pkg::IDX_CAP_LO, 8'h00);
    // Compare update in the safe order: high, status, low
    rd16(tcc_pkg::IDX_CNT_HI, c);
    t = c + 16'h000A + {13'h0, 3'($random(seed))};
    bus(1'h1, tcc_pkg::IDX_CTRL, 8'h40);
    bus(1'h1, tcc_pkg::IDX_CMP_HI, t[15:8]);
    bus(1'h0, tcc_pkg::IDX_STATUS, 8'h00);
    bus(1'h1, tcc_pkg::IDX_CMP_LO, t[7:0]);
    for (i = 0; i < 200 && irq !== 1'h1; i++) @(posedge clk_in);
    chk("compare irq", {15'h0, irq}, 16'h0001);
    if (irq !== 1'h1) wrap_up();
    stat("compare flag", 8'h40);
    bus(1'h1, tcc_pkg::IDX_CMP_LO, t[7:0]);
    stat("compare cleared", 8'h00);
    // Counter frozen in stop; the armed edge commits counter plus one on wake
    bus(1'h1, tcc_pkg::IDX_CTRL, 8'h02);
    pin_to(1'h0);
    stop_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rd16(tcc_pkg::IDX_CNT_HI, c);
    repeat (9) @(posedge clk_in);
    rd16(tcc_pkg::IDX_CNT_HI, v);
    chk("stop hold", v, c);
    pin_to(1'h1);
    stat("no flag in stop", 8'h00);
    stop_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    stat("flag on wake", 8'h80);
    rd16(tcc_pkg::IDX_CAP_HI, v);
    chk("stop capture", v, c + 16'h0001);
    wrap_up();
  end
endmodule : timer_capture_compare_unit_tb_top
